/* rtl/vpw_pkg.sv */
// constants and types for the vpw transmit dma and status block
package vpw_pkg;
    localparam int          DATA_W       = 32;
    localparam int          ADDR_W       = 32;
    localparam int          DMA_AW       = 16;
    localparam logic [7:0]  LINK_PAGE    = 8'h17;
    localparam logic [7:0]  IDX_STATUS   = 8'hf0;
    localparam logic [7:0]  IDX_TX_OPCODE_REG     = 8'hf1;
    localparam logic [7:0]  IDX_TXBYTE   = 8'hf2;
    localparam logic [7:0]  IDX_RXBYTE   = 8'hf3;
    localparam logic [7:0]  IDX_ERROR    = 8'hf4;
    localparam logic [7:0]  IDX_CONTROL  = 8'hf5;
    localparam logic [7:0]  IDX_IMR      = 8'hf6;
    localparam logic [7:0]  IDX_PRL      = 8'hf7;
    localparam logic [7:0]  IDX_OPTIONS  = 8'hf8;
    localparam logic [7:0]  IDX_DMAADR   = 8'hf9;
    localparam logic [7:0]  IDX_DMACNT   = 8'hfa;
    localparam logic [7:0]  IDX_PHYS     = 8'hfb;
    localparam logic [7:0]  IDX_STACK    = 8'hfc;
    localparam int          SUBPAGES     = 9;
    localparam int          STACK_REGS   = 4;
    localparam logic [7:0]  STATUS_RST   = 8'h40;
    localparam int          ST_ERR       = 7;
    localparam int          ST_TX_OPCODE_READY      = 6;
    localparam int          ST_RX_BYTE_FULL      = 5;
    localparam int          ST_TLA       = 4;
    localparam int          ST_RDT       = 3;
    localparam int          CTL_EN       = 0;
    localparam int          CTL_DIS      = 1;
    localparam int          IMR_TXDMA    = 0;
    localparam int          IMR_ERR      = 7;
    localparam int          PRL_TEOB     = 0;
    localparam int          OPT_SUSP     = 7;
    localparam int          ERR_TRA      = 0;
    localparam int          ERR_IBD      = 1;
    localparam int          ERR_IFD      = 2;
    localparam int          ERR_CRC      = 3;
    localparam int          ERR_BRK      = 4;
    localparam int          ERR_W        = 5;
    localparam logic [7:0]  CTL_RST      = 8'h00;
    localparam logic [7:0]  OP_RST       = 8'h00;
    localparam logic [2:0]  OP_MSG       = 3'h1;
    localparam logic [2:0]  OP_MSG_CRC   = 3'h2;
    localparam logic [2:0]  OP_IFR1      = 3'h3;
    localparam logic [2:0]  OP_IFR2      = 3'h4;
    localparam logic [2:0]  OP_IFR3      = 3'h5;
    localparam logic [2:0]  OP_IFR3_CRC  = 3'h6;
    localparam logic [15:0] DMA_ONE      = 16'h0001;

    typedef enum logic [1:0] {
        DMA_IDLE   = 2'b00,
        DMA_OP     = 2'b01,
        DMA_DECIDE = 2'b11,
        DMA_DATA   = 2'b10
    } vpw_dma_state_t;

    // message and type 3 opcodes carry the data byte
    function automatic logic vpw_needs_data(input logic [2:0] op);
        vpw_needs_data = (op == OP_MSG) || (op == OP_MSG_CRC) ||
                         (op == OP_IFR3) || (op == OP_IFR3_CRC);
    endfunction
endpackage

/* rtl/vpw_tx_dma_status.sv */
// vpw transmit dma sequencer, status flags and register file
`timescale 1ns/1ns
module vpw_tx_dma_status (
    input  wire logic                        hclk,
    input  wire logic                        hresetn,
    input  wire logic                        hsel,
    input  wire logic [vpw_pkg::ADDR_W-1:0]  haddr,
    input  wire logic [1:0]                  htrans,
    input  wire logic                        hwrite,
    input  wire logic [2:0]                  hsize,
    input  wire logic [vpw_pkg::DATA_W-1:0]  hwdata,
    input  wire logic                        hready,
    output logic      [vpw_pkg::DATA_W-1:0]  hrdata,
    output logic                             hreadyout,
    output logic                             hresp,
    output logic                             dma_req,
    output logic      [vpw_pkg::DMA_AW-1:0]  dma_addr,
    input  wire logic                        dma_ack,
    input  wire logic [7:0]                  dma_rdata,
    output logic      [7:0]                  tx_op_out,
    output logic      [7:0]                  tx_data_out,
    output logic                             tx_start,
    output logic                             tx_cancel_frame,
    output logic                             tx_cancel_all,
    output logic                             tx_passive,
    output logic                             err_irq,
    input  wire logic                        op_accept,
    input  wire logic                        op_next_frame,
    input  wire logic                        tx_abort_evt,
    input  wire logic                        lost_arb_evt,
    input  wire logic                        sending_ifr2,
    input  wire logic                        bit_err_evt,
    input  wire logic                        frame_err_evt,
    input  wire logic                        crc_err_evt,
    input  wire logic                        break_evt,
    input  wire logic                        end_of_data,
    input  wire logic                        rx_byte_done,
    input  wire logic [7:0]                  rx_byte_in,
    input  wire logic                        rx_is_ifr
);
    import vpw_pkg::*;

    logic [7:0]        control;
    logic [7:0]        interrupt_mask_reg;
    logic [7:0]        priority_level_reg;
    logic [7:0]        options;
    logic [7:0]        tx_opcode_reg;
    logic [7:0]        tx_byte_reg;
    logic [7:0]        rx_byte_reg;
    logic [7:0]        phys_addr_reg;
    logic [ERR_W-1:0]  error_reg;
    logic [15:0]       dma_count;
    logic              tx_opcode_ready;
    logic              rx_byte_full;
    logic              lost_arbitration_flag;
    logic              rx_byte_type;
    logic              op_wait_data;
    logic              wr_pend;
    logic [7:0]        wr_idx;
    logic [7:0]        stack_mem [SUBPAGES*STACK_REGS];
    logic [15:0]       rd_val;
    vpw_dma_state_t    state;

    ////////////////////////////////////////////////////////////////////////
    // bus decode
    logic       sel_ok;
    logic       page_ok;
    logic [7:0] idx;
    logic       rd_rx;
    logic [7:0] wdat;
    logic [3:0] subpage_select;
    logic [5:0] stack_idx;
    logic       stack_ok;
    logic       on;

    assign sel_ok  = hsel && hready && htrans[1];
    assign idx     = haddr[9:2];
    assign page_ok = (haddr[17:10] == LINK_PAGE) && (idx >= IDX_STATUS);
    assign rd_rx   = sel_ok && !hwrite && page_ok && (idx == IDX_RXBYTE);
    assign wdat    = hwdata[7:0];
    assign subpage_select = options[3:0];
    // stacked window at fc..ff indexed by subpage
    assign stack_idx = 6'(subpage_select) * 6'(STACK_REGS) +
                       6'(idx[1:0]);
    assign stack_ok  = subpage_select < 4'(SUBPAGES);
    assign on = control[CTL_EN] && !control[CTL_DIS];

    logic sw_op_wr;
    logic sw_byte_wr;
    logic dma_op_ld;
    logic dma_dat_ld;
    logic op_write;
    logic susp;
    logic tla_set;
    logic frame_err;
    logic tx_opcode_ready_set;
    logic last_xfer;

    assign sw_op_wr   = wr_pend && (wr_idx == IDX_TX_OPCODE_REG);
    assign sw_byte_wr = wr_pend && (wr_idx == IDX_TXBYTE);
    assign dma_op_ld  = (state == DMA_OP) && dma_ack;
    assign dma_dat_ld = (state == DMA_DATA) && dma_ack;
    assign op_write   = sw_op_wr || dma_op_ld;
    assign susp       = options[OPT_SUSP] &&
                        ((|error_reg) || lost_arbitration_flag);
    assign tla_set    = lost_arb_evt && !sending_ifr2;
    assign frame_err  = bit_err_evt || frame_err_evt || crc_err_evt;
    assign tx_opcode_ready_set   = op_accept || tx_abort_evt || break_evt ||
                        (lost_arb_evt && !op_next_frame) ||
                        (frame_err && !op_next_frame);
    assign last_xfer  = (dma_op_ld || dma_dat_ld) && (dma_count == DMA_ONE);

    always_comb begin
        rd_val = 16'h0000;
        unique case (idx)
            IDX_STATUS:  rd_val = {8'h00, on && (|error_reg),
                                   tx_opcode_ready, rx_byte_full,
                                   lost_arbitration_flag, rx_byte_type,
                                   3'h0};
            IDX_TX_OPCODE_REG:    rd_val = {8'h00, tx_opcode_reg};
            IDX_TXBYTE:  rd_val = {8'h00, tx_byte_reg};
            IDX_RXBYTE:  rd_val = {8'h00, rx_byte_reg};
            IDX_ERROR:   rd_val = {11'h000, error_reg};
            IDX_CONTROL: rd_val = {8'h00, control};
            IDX_IMR:     rd_val = {8'h00, interrupt_mask_reg};
            IDX_PRL:     rd_val = {8'h00, priority_level_reg};
            IDX_OPTIONS: rd_val = {8'h00, options};
            IDX_DMAADR:  rd_val = dma_addr;
            IDX_DMACNT:  rd_val = dma_count;
            IDX_PHYS:    rd_val = {8'h00, phys_addr_reg};
            default: begin
                if (stack_ok) begin
                    rd_val = {8'h00, stack_mem[stack_idx]};
                end
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // ahb-lite slave, zero wait states
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend   <= 1'b0;
            wr_idx    <= 8'h00;
            hrdata    <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            wr_pend   <= sel_ok && hwrite && page_ok;
            wr_idx    <= idx;
            if (sel_ok && !hwrite) begin
                hrdata <= page_ok ? {16'h0000, rd_val} : 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            control       <= CTL_RST;
            options       <= CTL_RST;
            tx_byte_reg   <= CTL_RST;
            phys_addr_reg <= CTL_RST;
        end else begin
            if (wr_pend) begin
                unique case (wr_idx)
                    IDX_CONTROL: control       <= wdat;
                    IDX_OPTIONS: options       <= wdat;
                    IDX_TXBYTE:  tx_byte_reg   <= wdat;
                    IDX_PHYS:    phys_addr_reg <= wdat;
                    default: ;
                endcase
            end
            // dma byte must not be lost to a bus write of the same register
            if (dma_dat_ld) begin
                tx_byte_reg <= dma_rdata;
            end
        end
    end

    for (genvar g = 0; g < SUBPAGES*STACK_REGS; g++) begin : g_stack
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                stack_mem[g] <= CTL_RST;
            end else if (wr_pend && (wr_idx >= IDX_STACK) &&
                         (6'(subpage_select) * 6'(STACK_REGS) +
                          6'(wr_idx[1:0]) == 6'(g)) && stack_ok) begin
                stack_mem[g] <= wdat;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // dma enable, end of block pending, address and count
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            interrupt_mask_reg <= CTL_RST;
            priority_level_reg <= CTL_RST;
        end else begin
            if (wr_pend && (wr_idx == IDX_IMR)) begin
                interrupt_mask_reg <= wdat;
            end
            if (last_xfer) begin
                interrupt_mask_reg[IMR_TXDMA] <= 1'b0;
            end
            if (wr_pend && (wr_idx == IDX_PRL)) begin
                priority_level_reg <= wdat;
            end
            if (last_xfer) begin
                priority_level_reg[PRL_TEOB] <= 1'b1;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dma_addr  <= 16'h0000;
            dma_count <= 16'h0000;
        end else if (dma_op_ld || dma_dat_ld) begin
            dma_addr  <= dma_addr + DMA_ONE;
            dma_count <= dma_count - DMA_ONE;
        end else if (wr_pend && (wr_idx == IDX_DMAADR)) begin
            dma_addr  <= hwdata[15:0];
        end else if (wr_pend && (wr_idx == IDX_DMACNT)) begin
            dma_count <= hwdata[15:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // dma sequencer
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state   <= DMA_IDLE;
            dma_req <= 1'b0;
        end else if (!on) begin
            state   <= DMA_IDLE;
            dma_req <= 1'b0;
        end else begin
            unique case (state)
                DMA_IDLE: begin
                    if (interrupt_mask_reg[IMR_TXDMA] && tx_opcode_ready &&
                        (dma_count != 16'h0000) && !susp) begin
                        state   <= DMA_OP;
                        dma_req <= 1'b1;
                    end
                end
                DMA_OP: begin
                    if (dma_ack) begin
                        state   <= DMA_DECIDE;
                        dma_req <= 1'b0;
                    end
                end
                DMA_DECIDE: begin
                    if (!vpw_needs_data(tx_opcode_reg[2:0]) ||
                        (dma_count == 16'h0000) ||
                        !interrupt_mask_reg[IMR_TXDMA]) begin
                        state <= DMA_IDLE;
                    end else if (!susp) begin
                        state   <= DMA_DATA;
                        dma_req <= 1'b1;
                    end
                end
                DMA_DATA: begin
                    if (dma_ack) begin
                        state   <= DMA_IDLE;
                        dma_req <= 1'b0;
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // opcode register and launch towards the encoder
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_opcode_reg <= OP_RST;
            op_wait_data  <= 1'b0;
            tx_op_out     <= OP_RST;
            tx_data_out   <= OP_RST;
            tx_start      <= 1'b0;
        end else begin
            tx_start <= 1'b0;
            if (op_write) begin
                tx_opcode_reg <= sw_op_wr ? wdat : dma_rdata;
                tx_op_out     <= sw_op_wr ? wdat : dma_rdata;
                // opcode first only legal while dma is enabled
                if (vpw_needs_data(sw_op_wr ? wdat[2:0] : dma_rdata[2:0]) &&
                    interrupt_mask_reg[IMR_TXDMA]) begin
                    op_wait_data <= 1'b1;
                end else begin
                    tx_start    <= 1'b1;
                    tx_data_out <= vpw_needs_data(sw_op_wr ? wdat[2:0] :
                                                  dma_rdata[2:0]) ?
                                   tx_byte_reg : phys_addr_reg;
                end
            end else if (op_wait_data && (dma_dat_ld || sw_byte_wr)) begin
                op_wait_data <= 1'b0;
                tx_start     <= 1'b1;
                tx_data_out  <= dma_dat_ld ? dma_rdata : wdat;
            end else if (break_evt || !on) begin
                op_wait_data <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // status flags
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_opcode_ready <= STATUS_RST[ST_TX_OPCODE_READY];
        end else if (!on || tx_opcode_ready_set) begin
            tx_opcode_ready <= 1'b1;
        end else if (op_write) begin
            tx_opcode_ready <= 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_byte_full <= STATUS_RST[ST_RX_BYTE_FULL];
            rx_byte_type <= STATUS_RST[ST_RDT];
            rx_byte_reg  <= OP_RST;
        end else if (!on) begin
            rx_byte_full <= 1'b0;
            rx_byte_type <= 1'b0;
        end else if (rx_byte_done) begin
            rx_byte_full <= 1'b1;
            rx_byte_type <= rx_is_ifr;
            rx_byte_reg  <= rx_byte_in;
        end else if (rd_rx) begin
            rx_byte_full <= 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            lost_arbitration_flag <= STATUS_RST[ST_TLA];
        end else if (!on) begin
            lost_arbitration_flag <= 1'b0;
        end else if (tla_set) begin
            lost_arbitration_flag <= 1'b1;
        end else if (wr_pend && (wr_idx == IDX_STATUS) && !wdat[ST_TLA]) begin
            lost_arbitration_flag <= 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            error_reg <= 5'h00;
        end else if (!on) begin
            error_reg <= 5'h00;
        end else begin
            error_reg <= ((wr_pend && (wr_idx == IDX_ERROR)) ?
                          (error_reg & wdat[ERR_W-1:0]) : error_reg) |
                         {break_evt, crc_err_evt, frame_err_evt,
                          bit_err_evt, tx_abort_evt};
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            err_irq <= 1'b0;
        end else begin
            err_irq <= on && (|error_reg) &&
                       interrupt_mask_reg[IMR_ERR];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // cancels and passive hold towards the encoder
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_cancel_frame <= 1'b0;
            tx_cancel_all   <= 1'b0;
            tx_passive      <= 1'b0;
        end else begin
            tx_cancel_frame <= on && (tla_set ||
                               (frame_err && !op_next_frame));
            tx_cancel_all   <= on && break_evt;
            if (!on || end_of_data) begin
                tx_passive <= 1'b0;
            end else if (tla_set) begin
                tx_passive <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence s_op_fetched;
        (state == DMA_OP) && dma_ack && vpw_needs_data(dma_rdata[2:0]) &&
        (dma_count > DMA_ONE) && interrupt_mask_reg[IMR_TXDMA];
    endsequence
    sequence s_two_byte_tail;
        ##1 (state == DMA_DECIDE) ##1 (state == DMA_DATA) ||
            $past(susp || !on || !interrupt_mask_reg[IMR_TXDMA]);
    endsequence

    a_dma_req_cause: assert property ($rose(dma_req) && state == DMA_OP
        |-> $past(tx_opcode_ready && interrupt_mask_reg[IMR_TXDMA]))
        else $error("dma request without ready and enable");
    a_two_byte_fetch: assert property (s_op_fetched and (!susp && on)
        |-> s_two_byte_tail)
        else $error("data byte not fetched after opcode");
    a_addr_count_step: assert property (dma_req && dma_ack
        |=> dma_addr == $past(dma_addr) + DMA_ONE &&
            dma_count == $past(dma_count) - DMA_ONE)
        else $error("dma address or count not stepped");
    a_eob_clears_en: assert property (last_xfer
        |=> !interrupt_mask_reg[IMR_TXDMA] && priority_level_reg[PRL_TEOB])
        else $error("end of block did not stop dma");
    a_suspend_hold: assert property (on && susp && state == DMA_IDLE
        |=> !dma_req)
        else $error("dma issued while suspended");
    a_status_forced: assert property (!on ##1 !on
        |-> rd_val == {8'h00, STATUS_RST} || idx != IDX_STATUS)
        else $error("status not forced while off");
    a_err_irq_mask: assert property (on && $past(on) && (|error_reg) &&
        interrupt_mask_reg[IMR_ERR] ##1 $stable(error_reg) |-> err_irq)
        else $error("error request missing");
    a_break_ready: assert property (on && break_evt
        |=> tx_opcode_ready && tx_cancel_all)
        else $error("break did not free transmitter");
    a_rx_full_set: assert property (on && rx_byte_done
        |=> rx_byte_full && rx_byte_type == $past(rx_is_ifr))
        else $error("receive full or type not updated");
    a_ifr2_no_tla: assert property (on && lost_arb_evt && sending_ifr2 &&
        !lost_arbitration_flag |=> !lost_arbitration_flag)
        else $error("type 2 loss set lost arbitration");
    a_passive_hold: assert property (on && tla_set && !end_of_data
        |=> tx_passive ##1 (tx_passive || $past(end_of_data || !on)))
        else $error("output not held passive after loss");
endmodule // vpw_tx_dma_status

/* test/vpw_mem_model.sv */
// table memory answering the transmit dma fetches
`timescale 1ns/1ns
module vpw_mem_model (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        dma_req,
    input  wire logic [15:0] dma_addr,
    input  wire logic [3:0]  slow,
    output logic             dma_ack,
    output logic [7:0]       dma_rdata
);
    logic [3:0] cnt;
    logic [7:0] tbl [0:3];
    // opcode with data, its byte, opcode without data
    initial tbl = '{8'h01, 8'ha5, 8'h03, 8'h00};
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt <= 4'h0;
            dma_ack <= 1'b0;
            dma_rdata <= 8'h00;
        end else if (dma_req && !dma_ack && cnt >= slow) begin
            cnt <= 4'h0;
            dma_ack <= 1'b1;
            dma_rdata <= tbl[dma_addr[1:0]];
        end else begin
            cnt <= dma_req ? cnt + 4'h1 : 4'h0;
            dma_ack <= 1'b0;
            dma_rdata <= ~dma_rdata;
        end
    end
endmodule // vpw_mem_model

/* test/tb_vpw_tx_dma_status.sv */
// bench for the vpw transmit dma and status block
`timescale 1ns/1ns
module tb_vpw_tx_dma_status;
    import vpw_pkg::*;
    logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, q = 0;
    logic [1:0] htrans = 0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
    logic hreadyout, dma_req, dma_ack, tx_start, err_irq, op_accept = 0;
    logic bit_err_evt = 0, rx_byte_done = 0, rx_is_ifr = 0;
    logic lost_arb_evt = 0, sending_ifr2 = 0, break_evt = 0;
    logic end_of_data = 0, tx_cancel_frame, tx_cancel_all, tx_passive;
    logic [15:0] dma_addr;
    logic [7:0] dma_rdata, tx_op_out, tx_data_out, rx_byte_in = 0;
    logic [3:0] slow = 0;
    int failures = 0, checked = 0;
    vpw_tx_dma_status i_vpw_tx_dma_status (
        .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
        .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp(),
        .dma_req, .dma_addr, .dma_ack, .dma_rdata, .tx_op_out,
        .tx_data_out, .tx_start, .tx_cancel_frame, .tx_cancel_all,
        .tx_passive, .err_irq, .op_accept, .op_next_frame(q),
        .tx_abort_evt(q), .lost_arb_evt, .sending_ifr2,
        .bit_err_evt, .frame_err_evt(bit_err_evt),
        .crc_err_evt(bit_err_evt), .break_evt, .end_of_data,
        .rx_byte_done, .rx_byte_in, .rx_is_ifr);
    vpw_mem_model i_vpw_mem_model (.hclk, .hresetn, .dma_req, .dma_addr,
        .slow, .dma_ack, .dma_rdata);
    always #5 hclk = ~hclk;
    // encoder stand-in accepts each launched opcode
    always @(posedge hclk) op_accept <= tx_start;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic final_report;
        if (failures == 0 && checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // wait for an edge, or a negedge pulse of tx_start, bounded
    task automatic waitfor(input logic pulse);
        int n;
        n = 0;
        do begin
            if (pulse) @(negedge hclk);
            else @(posedge hclk);
            n++;
        end while ((pulse ? tx_start : hreadyout) !== 1'b1 && n < 300);
        if (n >= 300) begin
            failures++;
            final_report;
        end
    endtask
    task automatic bus(input logic [7:0] idx, input logic w,
                       input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr <= {14'h0, LINK_PAGE, idx, 2'b00};
        waitfor(1'b0);
        htrans <= 2'b00;
        hwdata <= wd;
        waitfor(1'b0);
        rd = hrdata;
    endtask
    task automatic rc(input logic [7:0] idx, input logic [31:0] e);
        bus(idx, 1'b0, 32'h0);
        chk(rd, e);
    endtask
    task automatic t_reset;
        rc(IDX_STATUS, 32'h40);
        rc(8'h10, 32'h0);
        bus(IDX_CONTROL, 1'b1, 32'h3);
        rc(IDX_STATUS, 32'h40);
    endtask
    task automatic t_dma;
        slow <= 4'h3;
        bus(IDX_CONTROL, 1'b1, 32'h1);
        bus(IDX_DMAADR, 1'b1, 32'h0);
        bus(IDX_DMACNT, 1'b1, 32'h3);
        bus(IDX_IMR, 1'b1, 32'h1);
        waitfor(1'b1);
        chk({tx_op_out, tx_data_out}, 32'h01a5);
        waitfor(1'b1);
        chk(tx_op_out, 32'h03);
        @(posedge hclk);
        rc(IDX_DMAADR, 32'h3);
        rc(IDX_DMACNT, 32'h0);
        rc(IDX_IMR, 32'h0);
        rc(IDX_PRL, 32'h1);
    endtask
    task automatic t_err;
        bus(IDX_IMR, 1'b1, 32'h80);
        bus(IDX_OPTIONS, 1'b1, 32'h80);
        bus(IDX_DMACNT, 1'b1, 32'h1);
        bit_err_evt <= 1'b1;
        @(posedge hclk);
        bit_err_evt <= 1'b0;
        @(posedge hclk);
        rc(IDX_STATUS, 32'hc0);
        chk(err_irq, 1'b1);
        bus(IDX_IMR, 1'b1, 32'h81);
        repeat (8) @(posedge hclk);
        chk(dma_req, 1'b0);
        bus(IDX_ERROR, 1'b1, 32'h0);
        waitfor(1'b1);
        chk(tx_op_out, 32'h00);
        @(posedge hclk);
        rc(IDX_IMR, 32'h80);
        rc(IDX_STATUS, 32'h40);
        chk(err_irq, 1'b0);
    endtask
    task automatic t_arb;
        lost_arb_evt <= 1'b1;
        @(posedge hclk);
        lost_arb_evt <= 1'b0;
        @(negedge hclk);
        chk({tx_passive, tx_cancel_frame}, 32'h3);
        @(posedge hclk);
        end_of_data <= 1'b1;
        @(posedge hclk);
        end_of_data <= 1'b0;
        @(negedge hclk);
        chk(tx_passive, 1'b0);
        @(posedge hclk);
        rc(IDX_STATUS, 32'h50);
        bus(IDX_STATUS, 1'b1, 32'h0);
        lost_arb_evt <= 1'b1;
        sending_ifr2 <= 1'b1;
        @(posedge hclk);
        lost_arb_evt <= 1'b0;
        @(posedge hclk);
        rc(IDX_STATUS, 32'h40);
        break_evt <= 1'b1;
        @(posedge hclk);
        break_evt <= 1'b0;
        @(negedge hclk);
        chk(tx_cancel_all, 1'b1);
        @(posedge hclk);
        rc(IDX_STATUS, 32'hc0);
        bus(IDX_ERROR, 1'b1, 32'h0);
    endtask
    task automatic t_rx;
        rx_byte_in <= 8'h5a;
        rx_is_ifr <= 1'b1;
        rx_byte_done <= 1'b1;
        @(posedge hclk);
        rx_byte_done <= 1'b0;
        @(posedge hclk);
        rc(IDX_STATUS, 32'h68);
        rc(IDX_RXBYTE, 32'h5a);
        rc(IDX_STATUS, 32'h48);
        bus(IDX_CONTROL, 1'b1, 32'h0);
        @(posedge hclk);
        rc(IDX_STATUS, 32'h40);
    endtask
    initial begin
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_reset;
        t_dma;
        t_err;
        t_arb;
        t_rx;
        final_report;
    end
endmodule // tb_vpw_tx_dma_status
